// ---- mfsc_pkg.sv ----
// Shared constants and types for the MAC frame statistics counters
package mfsc_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int LEN_W  = 16;           // Frame and attempt byte lengths
	localparam int WIRE_W = LEN_W + 1;    // Frame bytes plus attempt bytes in one cycle
	localparam int CNT_W  = 32;           // Every statistics counter

	typedef logic [LEN_W-1:0]  mfsc_len_t;
	typedef logic [WIRE_W-1:0] mfsc_wire_t;
	typedef logic [CNT_W-1:0]  mfsc_cnt_t;

	// ****************************************************************
	// Event counter slots: six size buckets, then three overrun kinds
	// ****************************************************************
	localparam int N_BKT   = 6;
	localparam int N_EVT   = 9;
	localparam int EVT_MIN = 0;
	localparam int EVT_SML = 1;
	localparam int EVT_MED = 2;
	localparam int EVT_MDL = 3;
	localparam int EVT_LRG = 4;
	localparam int EVT_MAX = 5;
	localparam int EVT_SOF = 6;
	localparam int EVT_MOF = 7;
	localparam int EVT_DMA = 8;

	// ****************************************************************
	// Size bucket bounds, inclusive, in bytes
	// ****************************************************************
	localparam mfsc_len_t LEN_MIN_FRAME = 16'h0040;
	localparam mfsc_len_t BKT_LO [N_BKT] = '{16'h0040, 16'h0041, 16'h0080,
		16'h0100, 16'h0200, 16'h0400};
	localparam mfsc_len_t BKT_HI [N_BKT] = '{16'h0040, 16'h007F, 16'h00FF,
		16'h01FF, 16'h03FF, 16'h05EE};

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam mfsc_cnt_t  CNT_RESET  = 32'h0000_0000;
	localparam mfsc_cnt_t  CNT_ONE    = 32'h0000_0001;
	localparam mfsc_len_t  LEN_ZERO   = 16'h0000;
	localparam mfsc_wire_t WIRE_ZERO  = 17'h0_0000;
	localparam logic [N_EVT-1:0] EVT_NONE = 9'h000;

endpackage

// ---- mfsc_event_if.sv ----
// Carrier between the frame classifier and the counter bank
`timescale 1ns/1ns
interface mfsc_event_if;
	import mfsc_pkg::*;

	// Frame status presented to the classifier
	logic             done;
	logic             is_tx;
	mfsc_len_t        bytes;
	logic             late_coll;
	logic             excess_coll;
	logic             carrier_loss;
	logic             underrun;
	logic             addr_match;
	logic             sof_overrun;
	logic             mof_overrun;
	logic             zero_head;
	logic             attempt;
	mfsc_len_t        attempt_bytes;

	// Classified increments, one cycle after the status
	logic [N_EVT-1:0] evt_inc;
	mfsc_len_t        tx_add;
	mfsc_wire_t       wire_add;

	modport classify (
		input  done, is_tx, bytes, late_coll, excess_coll, carrier_loss, underrun,
		input  addr_match, sof_overrun, mof_overrun, zero_head, attempt, attempt_bytes,
		output evt_inc, tx_add, wire_add
	);

	modport count (
		output done, is_tx, bytes, late_coll, excess_coll, carrier_loss, underrun,
		output addr_match, sof_overrun, mof_overrun, zero_head, attempt, attempt_bytes,
		input  evt_inc, tx_add, wire_add
	);

endinterface

// ---- mfsc_frame_classify.sv ----
// Frame classifier: turns one frame status into per-counter increments
`timescale 1ns/1ns
module mfsc_frame_classify
	import mfsc_pkg::*;
(
	input  wire logic      clk_sys,
	input  wire logic      reset_n,
	mfsc_event_if.classify ev
);

	// ****************************************************************
	// Qualification terms
	// ****************************************************************
	logic             clean;
	logic             bucket_ok;
	logic             rx_ovr_ok;
	logic             tx_good;
	logic [N_EVT-1:0] evt_nxt;

	// No late or excessive collision and no underrun
	assign clean = !ev.late_coll && !ev.excess_coll && !ev.underrun;

	// Carrier loss bars a transmit frame, unless it left exactly the minimum size
	assign bucket_ok = ev.done && clean
		&& !(ev.is_tx && ev.carrier_loss && ev.bytes != LEN_MIN_FRAME);

	// Overruns only apply to received frames that matched an address
	assign rx_ovr_ok = ev.done && !ev.is_tx && ev.addr_match;

	// CRC, alignment and code errors never reach this block, so they cannot veto
	assign tx_good = ev.done && ev.is_tx && clean && !ev.carrier_loss;

	// ****************************************************************
	// Size buckets, one comparator pair per bucket
	// ****************************************************************
	genvar b;
	generate
		for (b = 0; b < N_BKT; b++) begin : g_bkt
			// Receive overruns do not disqualify a bucket hit
			assign evt_nxt[b] = bucket_ok && ev.bytes >= BKT_LO[b]
				&& ev.bytes <= BKT_HI[b];
		end
	endgenerate

	// Overrun kinds; a middle overrun only counts when the start was accepted
	assign evt_nxt[EVT_SOF] = rx_ovr_ok && ev.sof_overrun;
	assign evt_nxt[EVT_MOF] = rx_ovr_ok && ev.mof_overrun && !ev.sof_overrun;
	assign evt_nxt[EVT_DMA] = rx_ovr_ok && ev.zero_head;

	// Event increments registered so the counter bank sees a clean vector
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ev.evt_inc <= EVT_NONE;
		end else begin
			ev.evt_inc <= evt_nxt;
		end
	end

	// Good transmit bytes
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ev.tx_add <= LEN_ZERO;
		end else begin
			ev.tx_add <= tx_good ? ev.bytes : LEN_ZERO;
		end
	end

	// Wire bytes: every finished frame plus every partial attempt, no error veto
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ev.wire_add <= WIRE_ZERO;
		end else begin
			ev.wire_add <= WIRE_W'(ev.done ? ev.bytes : LEN_ZERO)
				+ WIRE_W'(ev.attempt ? ev.attempt_bytes : LEN_ZERO);
		end
	end

endmodule

// ---- mfsc_stats_top.sv ----
// Frame statistics counter bank: size buckets, byte totals and overruns
//
// Functional notes
// - Good transmit bytes add lengths of frames without collision faults, carrier loss, underrun.
// - Minimum bucket counts clean sixty-four byte frames, either direction.
// - Transmit frame truncated by carrier loss to sixty-four bytes still counts.
// - Size buckets ignore CRC, alignment, code errors and receive overruns.
// - Small bucket counts clean frames of 65 to 127 bytes.
// - Medium bucket counts clean frames of 128 to 255 bytes.
// - Mid-large bucket counts clean frames of 256 to 511 bytes.
// - Large bucket counts clean frames of 512 to 1023 bytes.
// - Max bucket counts clean frames of 1024 to 1518 bytes.
// - Wire byte total adds every frame, any address, any length.
// - Wire byte total adds bytes before carrier loss and each collided attempt.
// - Half-duplex receive bytes count up to the jam; jam bytes never count.
// - No frame error stops the wire byte total from accumulating.
// - Start overrun counts matched receive frames refused at their start.
// - Middle overrun counts matched frames that lost resources after a clean start.
// - Descriptor overrun counts matched frames meeting a zero head descriptor.
// - Overrun counters ignore CRC, alignment and code errors.
`timescale 1ns/1ns
module mfsc_stats_top
	import mfsc_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 reset_n,
	input  wire logic                 frame_done,
	input  wire logic                 frame_is_tx,
	input  wire mfsc_pkg::mfsc_len_t  frame_bytes,
	input  wire logic                 frame_late_coll,
	input  wire logic                 frame_excess_coll,
	input  wire logic                 frame_carrier_loss,
	input  wire logic                 frame_underrun,
	input  wire logic                 frame_addr_match,
	input  wire logic                 frame_sof_overrun,
	input  wire logic                 frame_middle_overrun,
	input  wire logic                 frame_zero_head,
	input  wire logic                 attempt_done,
	input  wire mfsc_pkg::mfsc_len_t  attempt_bytes,
	output logic [mfsc_pkg::CNT_W-1:0] tx_good_byte_count,
	output logic [mfsc_pkg::CNT_W-1:0] size_bucket_min,
	output logic [mfsc_pkg::CNT_W-1:0] size_bucket_small,
	output logic [mfsc_pkg::CNT_W-1:0] size_bucket_medium,
	output logic [mfsc_pkg::CNT_W-1:0] size_bucket_mid_large,
	output logic [mfsc_pkg::CNT_W-1:0] size_bucket_large,
	output logic [mfsc_pkg::CNT_W-1:0] size_bucket_max,
	output logic [mfsc_pkg::CNT_W-1:0] wire_utilisation_bytes,
	output logic [mfsc_pkg::CNT_W-1:0] rx_start_overrun_count,
	output logic [mfsc_pkg::CNT_W-1:0] rx_middle_overrun_count,
	output logic [mfsc_pkg::CNT_W-1:0] rx_descriptor_overrun_count
);
	import mfsc_pkg::*;

	// ****************************************************************
	// Classifier stage
	// ****************************************************************
	mfsc_event_if ev ();

	// Status inputs come from MAC logic on this clock, so no synchroniser
	assign ev.done          = frame_done;
	assign ev.is_tx         = frame_is_tx;
	assign ev.bytes         = frame_bytes;
	assign ev.late_coll     = frame_late_coll;
	assign ev.excess_coll   = frame_excess_coll;
	assign ev.carrier_loss  = frame_carrier_loss;
	assign ev.underrun      = frame_underrun;
	assign ev.addr_match    = frame_addr_match;
	assign ev.sof_overrun   = frame_sof_overrun;
	assign ev.mof_overrun   = frame_middle_overrun;
	assign ev.zero_head     = frame_zero_head;
	assign ev.attempt       = attempt_done;
	assign ev.attempt_bytes = attempt_bytes;

	mfsc_frame_classify u_classify (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.ev      (ev)
	);

	// ****************************************************************
	// Counter bank
	// ****************************************************************
	mfsc_cnt_t evt_cnt_r [N_EVT];
	mfsc_cnt_t tx_bytes_r;
	mfsc_cnt_t wire_bytes_r;

	// One incrementer per event counter; wraps silently at full scale
	genvar e;
	generate
		for (e = 0; e < N_EVT; e++) begin : g_evt
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					evt_cnt_r[e] <= CNT_RESET;
				end else if (ev.evt_inc[e]) begin
					evt_cnt_r[e] <= evt_cnt_r[e] + CNT_ONE;
				end
			end
		end
	endgenerate

	// Good transmit byte accumulator
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tx_bytes_r <= CNT_RESET;
		end else begin
			tx_bytes_r <= tx_bytes_r + CNT_W'(ev.tx_add);
		end
	end

	// Wire byte accumulator; jam bytes are never reported, so never counted
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wire_bytes_r <= CNT_RESET;
		end else begin
			wire_bytes_r <= wire_bytes_r + CNT_W'(ev.wire_add);
		end
	end

	// Outputs are the counter flops themselves
	assign tx_good_byte_count          = tx_bytes_r;
	assign size_bucket_min             = evt_cnt_r[EVT_MIN];
	assign size_bucket_small           = evt_cnt_r[EVT_SML];
	assign size_bucket_medium          = evt_cnt_r[EVT_MED];
	assign size_bucket_mid_large       = evt_cnt_r[EVT_MDL];
	assign size_bucket_large           = evt_cnt_r[EVT_LRG];
	assign size_bucket_max             = evt_cnt_r[EVT_MAX];
	assign wire_utilisation_bytes      = wire_bytes_r;
	assign rx_start_overrun_count      = evt_cnt_r[EVT_SOF];
	assign rx_middle_overrun_count     = evt_cnt_r[EVT_MOF];
	assign rx_descriptor_overrun_count = evt_cnt_r[EVT_DMA];

	// ****************************************************************
	// Checks: a status at edge t shows in the counters at edge t+2
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	logic chk_clean;
	logic chk_tx_good;
	logic chk_rx_ovr;

	// Mirrors of the qualification, used only by the checks
	assign chk_clean   = !frame_late_coll && !frame_excess_coll && !frame_underrun;
	assign chk_tx_good = frame_done && frame_is_tx && chk_clean && !frame_carrier_loss;
	assign chk_rx_ovr  = frame_done && !frame_is_tx && frame_addr_match;

	a_tx_good_add: assert property (
		chk_tx_good |-> ##2 (tx_good_byte_count - $past(tx_good_byte_count))
			== CNT_W'($past(frame_bytes, 2)))
		else $error("good transmit bytes not added");

	a_tx_bad_skip: assert property (
		!chk_tx_good |-> ##2 tx_good_byte_count == $past(tx_good_byte_count))
		else $error("transmit byte total moved without a good frame");

	a_min_bucket_hit: assert property (
		frame_done && chk_clean && !frame_carrier_loss && frame_bytes == LEN_MIN_FRAME
		|-> ##2 size_bucket_min == $past(size_bucket_min) + CNT_ONE)
		else $error("minimum bucket missed a clean frame");

	a_min_trunc_hit: assert property (
		frame_done && frame_is_tx && frame_carrier_loss && chk_clean
		&& frame_bytes == LEN_MIN_FRAME
		|-> ##2 size_bucket_min == $past(size_bucket_min) + CNT_ONE)
		else $error("truncated minimum frame not counted");

	a_trunc_other_skip: assert property (
		frame_done && frame_is_tx && frame_carrier_loss && frame_bytes != LEN_MIN_FRAME
		|-> ##2 $stable(size_bucket_small) && $stable(size_bucket_max))
		else $error("carrier loss frame counted in a larger bucket");

	a_dirty_skip: assert property (
		frame_done && !chk_clean |-> ##2 $stable(size_bucket_min)
			&& $stable(size_bucket_medium) && $stable(size_bucket_large))
		else $error("faulted frame counted in a size bucket");

	a_overrun_no_veto: assert property (
		frame_done && !frame_is_tx && frame_sof_overrun && chk_clean
		&& frame_bytes >= BKT_LO[EVT_MAX] && frame_bytes <= BKT_HI[EVT_MAX]
		|-> ##2 size_bucket_max == $past(size_bucket_max) + CNT_ONE)
		else $error("overrun suppressed a size bucket count");

	generate
		for (e = 0; e < N_BKT; e++) begin : g_chk
			a_bucket_range: assert property (
				frame_done && chk_clean && !frame_carrier_loss
				&& frame_bytes >= BKT_LO[e] && frame_bytes <= BKT_HI[e]
				|-> ##2 evt_cnt_r[e] == $past(evt_cnt_r[e]) + CNT_ONE)
				else $error("size bucket missed an in-range frame");
		end
	endgenerate

	a_wire_sum: assert property (
		1'b1 |-> ##2 (wire_utilisation_bytes - $past(wire_utilisation_bytes))
			== CNT_W'($past(frame_done, 2) ? $past(frame_bytes, 2) : LEN_ZERO)
			+ CNT_W'($past(attempt_done, 2) ? $past(attempt_bytes, 2) : LEN_ZERO))
		else $error("wire byte total wrong");

	a_wire_attempt: assert property (
		attempt_done && !frame_done |-> ##2 (wire_utilisation_bytes
			- $past(wire_utilisation_bytes)) == CNT_W'($past(attempt_bytes, 2)))
		else $error("partial attempt bytes not added");

	a_wire_err_add: assert property (
		frame_done && !attempt_done && (frame_underrun || frame_sof_overrun)
		|-> ##2 (wire_utilisation_bytes - $past(wire_utilisation_bytes))
			== CNT_W'($past(frame_bytes, 2)))
		else $error("errored frame bytes lost from wire total");

	a_sof_count: assert property (
		chk_rx_ovr && frame_sof_overrun
		|-> ##2 rx_start_overrun_count == $past(rx_start_overrun_count) + CNT_ONE)
		else $error("start overrun not counted");

	a_mof_count: assert property (
		chk_rx_ovr && frame_middle_overrun && !frame_sof_overrun
		|-> ##2 rx_middle_overrun_count == $past(rx_middle_overrun_count) + CNT_ONE)
		else $error("middle overrun not counted");

	a_mof_after_sof: assert property (
		frame_done && frame_sof_overrun |-> ##2 $stable(rx_middle_overrun_count))
		else $error("middle overrun counted after a start overrun");

	a_dma_count: assert property (
		chk_rx_ovr && frame_zero_head
		|-> ##2 rx_descriptor_overrun_count
			== $past(rx_descriptor_overrun_count) + CNT_ONE)
		else $error("descriptor overrun not counted");

	a_ovr_unmatched: assert property (
		frame_done && (frame_is_tx || !frame_addr_match)
		|-> ##2 $stable(rx_start_overrun_count) && $stable(rx_descriptor_overrun_count))
		else $error("overrun counted for an unmatched frame");

	a_idle_stable: assert property (
		!frame_done && !attempt_done |-> ##2 $stable(size_bucket_min)
			&& $stable(rx_start_overrun_count) && $stable(tx_good_byte_count)
			&& $stable(wire_utilisation_bytes))
		else $error("counter moved with no frame status");

endmodule

// ---- mfsc_mac_model.sv ----
// Behavioural model of the MAC transmit and receive frame status paths
`timescale 1ns/1ns
module mfsc_mac_model
	import mfsc_pkg::*;
(
	input  wire logic          clk_sys,
	output logic               frame_done,
	output logic               frame_is_tx,
	output mfsc_pkg::mfsc_len_t frame_bytes,
	output logic               frame_late_coll,
	output logic               frame_excess_coll,
	output logic               frame_carrier_loss,
	output logic               frame_underrun,
	output logic               frame_addr_match,
	output logic               frame_sof_overrun,
	output logic               frame_middle_overrun,
	output logic               frame_zero_head,
	output logic               attempt_done,
	output mfsc_pkg::mfsc_len_t attempt_bytes
);
	import mfsc_pkg::*;

	logic [7:0] flags_r;

	// ****************************************************************
	// Status flags, bit 7 down to 0: late, excess, carrier, underrun,
	// match, start overrun, middle overrun, zero head
	// ****************************************************************
	assign {frame_late_coll, frame_excess_coll, frame_carrier_loss, frame_underrun,
		frame_addr_match, frame_sof_overrun, frame_middle_overrun, frame_zero_head} = flags_r;

	// Quiet status at time zero
	initial begin
		frame_done = 1'b0;
		frame_is_tx = 1'b0;
		frame_bytes = 16'h0000;
		flags_r = 8'h00;
		attempt_done = 1'b0;
		attempt_bytes = 16'h0000;
	end

	// One status cycle, launched on the falling edge
	task automatic drive(input logic fd, input logic tx, input mfsc_len_t nb,
		input logic [7:0] fl, input logic ad, input mfsc_len_t ab);
		@(negedge clk_sys);
		frame_done = fd;
		frame_is_tx = tx;
		frame_bytes = nb;
		flags_r = fl;
		attempt_done = ad;
		attempt_bytes = ab;
	endtask

	// Released fields flip so that a missing qualifier cannot hide
	task automatic idle();
		@(negedge clk_sys);
		frame_done = 1'b0;
		attempt_done = 1'b0;
		frame_is_tx = ~frame_is_tx;
		frame_bytes = ~frame_bytes;
		flags_r = ~flags_r;
		attempt_bytes = ~attempt_bytes;
	endtask
endmodule

// ---- mac_frame_statistics_counters_tb.sv ----
// Self-checking testbench for the frame statistics counter bank
`timescale 1ns/1ns
module mac_frame_statistics_counters_tb;
	import mfsc_pkg::*;

	localparam int B_LO [6] = '{64, 65, 128, 256, 512, 1024};
	localparam int B_HI [6] = '{64, 127, 255, 511, 1023, 1518};
	localparam mfsc_len_t JUNK = 16'h1234;

	logic      clk_sys;
	logic      reset_n;
	logic      frame_done, frame_is_tx, frame_late_coll, frame_excess_coll;
	logic      frame_carrier_loss, frame_underrun, frame_addr_match;
	logic      frame_sof_overrun, frame_middle_overrun, frame_zero_head, attempt_done;
	mfsc_len_t frame_bytes, attempt_bytes;
	mfsc_cnt_t tx_good_byte_count, wire_utilisation_bytes;
	mfsc_cnt_t rx_start_overrun_count, rx_middle_overrun_count, rx_descriptor_overrun_count;
	mfsc_cnt_t bkt [N_BKT];
	mfsc_cnt_t e_tx, e_w, e_sof, e_mof, e_dma;
	mfsc_cnt_t e_b [N_BKT];
	int        failures;
	int        n_checks;

	// ****************************************************************
	// Clock, design and status model
	// ****************************************************************
	initial clk_sys = 1'b0;
	always #10 clk_sys = ~clk_sys;

	mfsc_stats_top uut (.clk_sys(clk_sys), .reset_n(reset_n), .frame_done(frame_done),
		.frame_is_tx(frame_is_tx), .frame_bytes(frame_bytes),
		.frame_late_coll(frame_late_coll), .frame_excess_coll(frame_excess_coll),
		.frame_carrier_loss(frame_carrier_loss), .frame_underrun(frame_underrun),
		.frame_addr_match(frame_addr_match), .frame_sof_overrun(frame_sof_overrun),
		.frame_middle_overrun(frame_middle_overrun), .frame_zero_head(frame_zero_head),
		.attempt_done(attempt_done), .attempt_bytes(attempt_bytes),
		.tx_good_byte_count(tx_good_byte_count), .size_bucket_min(bkt[0]),
		.size_bucket_small(bkt[1]), .size_bucket_medium(bkt[2]),
		.size_bucket_mid_large(bkt[3]), .size_bucket_large(bkt[4]),
		.size_bucket_max(bkt[5]), .wire_utilisation_bytes(wire_utilisation_bytes),
		.rx_start_overrun_count(rx_start_overrun_count),
		.rx_middle_overrun_count(rx_middle_overrun_count),
		.rx_descriptor_overrun_count(rx_descriptor_overrun_count));

	mfsc_mac_model mac_model (.clk_sys(clk_sys), .frame_done(frame_done),
		.frame_is_tx(frame_is_tx), .frame_bytes(frame_bytes),
		.frame_late_coll(frame_late_coll), .frame_excess_coll(frame_excess_coll),
		.frame_carrier_loss(frame_carrier_loss), .frame_underrun(frame_underrun),
		.frame_addr_match(frame_addr_match), .frame_sof_overrun(frame_sof_overrun),
		.frame_middle_overrun(frame_middle_overrun), .frame_zero_head(frame_zero_head),
		.attempt_done(attempt_done), .attempt_bytes(attempt_bytes));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic cmp(input string what, input mfsc_cnt_t exp, input mfsc_cnt_t got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Let the two-edge answer land, then compare every counter
	task automatic check_all();
		mac_model.idle();
		repeat (3) @(negedge clk_sys);
		cmp("tx_good_byte_count", e_tx, tx_good_byte_count);
		cmp("size_bucket_min", e_b[0], bkt[0]);
		cmp("size_bucket_small", e_b[1], bkt[1]);
		cmp("size_bucket_medium", e_b[2], bkt[2]);
		cmp("size_bucket_mid_large", e_b[3], bkt[3]);
		cmp("size_bucket_large", e_b[4], bkt[4]);
		cmp("size_bucket_max", e_b[5], bkt[5]);
		cmp("wire_utilisation_bytes", e_w, wire_utilisation_bytes);
		cmp("rx_start_overrun_count", e_sof, rx_start_overrun_count);
		cmp("rx_middle_overrun_count", e_mof, rx_middle_overrun_count);
		cmp("rx_descriptor_overrun_count", e_dma, rx_descriptor_overrun_count);
	endtask

	// Send one status cycle and advance the expected counters by hand
	task automatic ev(input logic fd, input logic tx, input mfsc_len_t nb,
		input logic [7:0] fl, input logic ad, input mfsc_len_t ab);
		logic ok;
		mac_model.drive(fd, tx, nb, fl, ad, ab);
		if (fd) begin
			e_w = e_w + {16'h0000, nb};
			ok = !fl[7] && !fl[6] && !fl[4] && !(tx && fl[5] && nb != 16'h0040);
			for (int i = 0; i < N_BKT; i++) begin
				if (ok && nb >= B_LO[i] && nb <= B_HI[i]) begin
					e_b[i] = e_b[i] + 32'h0000_0001;
				end
			end
			if (tx && fl[7:4] == 4'h0) begin
				e_tx = e_tx + {16'h0000, nb};
			end
			if (!tx && fl[3]) begin
				e_sof = e_sof + {31'h0000_0000, fl[2]};
				e_mof = e_mof + {31'h0000_0000, fl[1] & ~fl[2]};
				e_dma = e_dma + {31'h0000_0000, fl[0]};
			end
		end
		if (ad) begin
			e_w = e_w + {16'h0000, ab};
		end
	endtask

	// Reset held for twelve cycles; every counter must read zero after it
	task automatic do_reset();
		@(negedge clk_sys);
		reset_n = 1'b0;
		repeat (12) @(negedge clk_sys);
		reset_n = 1'b1;
		e_tx = '0;
		e_w = '0;
		e_sof = '0;
		e_mof = '0;
		e_dma = '0;
		e_b = '{default: '0};
	endtask

	// Good and faulted transmits, first one after the post-reset check of every counter
	task automatic t_tx_good();
		ev(1'b1, 1'b1, 16'h0040, 8'h00, 1'b0, JUNK);
		ev(1'b1, 1'b1, 16'h0064, 8'h80, 1'b0, JUNK);
		ev(1'b1, 1'b1, 16'h00C8, 8'h40, 1'b0, JUNK);
		ev(1'b1, 1'b1, 16'h012C, 8'h10, 1'b0, JUNK);
		ev(1'b1, 1'b1, 16'h05EE, 8'h00, 1'b0, JUNK);
		check_all();
	endtask

	// Every bucket edge back to back, overruns on every receive frame, which are the even-numbered ones
	task automatic t_buckets();
		int lens [13] = '{63, 64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024, 1518, 1519};
		for (int i = 0; i < 13; i++) begin
			ev(1'b1, i[0], 16'(lens[i]), (i[0] ? 8'h00 : 8'h0E), 1'b0, JUNK);
		end
		check_all();
	endtask

	// Carrier loss truncation and per-attempt wire bytes
	task automatic t_carrier();
		ev(1'b1, 1'b1, 16'h0040, 8'h20, 1'b0, JUNK);
		ev(1'b1, 1'b1, 16'h0064, 8'h20, 1'b1, 16'h0028);
		ev(1'b0, 1'b1, JUNK, 8'h00, 1'b1, 16'h003C);
		ev(1'b0, 1'b1, JUNK, 8'h00, 1'b1, 16'h003D);
		ev(1'b0, 1'b0, JUNK, 8'h00, 1'b1, 16'h012C);
		check_all();
	endtask

	// Overrun kinds, mixes of them, unmatched and transmit frames
	task automatic t_overrun();
		ev(1'b1, 1'b0, 16'h0020, 8'h0C, 1'b0, JUNK);
		ev(1'b1, 1'b0, 16'h0100, 8'h0A, 1'b0, JUNK);
		ev(1'b1, 1'b0, 16'h07D0, 8'h09, 1'b0, JUNK);
		ev(1'b1, 1'b0, 16'h0050, 8'h0D, 1'b0, JUNK);
		ev(1'b1, 1'b0, 16'h0050, 8'h07, 1'b0, JUNK);
		ev(1'b1, 1'b1, 16'h0050, 8'h0F, 1'b0, JUNK);
		check_all();
	endtask

	// Reset in mid-run clears the bank, counting resumes after
	task automatic t_midreset();
		ev(1'b1, 1'b1, 16'h0080, 8'h00, 1'b1, 16'h0010);
		// Quiet the status first, else the held pulse is taken again after release
		mac_model.idle();
		do_reset();
		check_all();
		ev(1'b1, 1'b0, 16'h0200, 8'h0C, 1'b0, JUNK);
		check_all();
	endtask

	task automatic end_sim();
		if (failures == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		failures = 0;
		n_checks = 0;
		reset_n = 1'b0;
		do_reset();
		check_all();
		t_tx_good();
		t_buckets();
		t_carrier();
		t_overrun();
		t_midreset();
		end_sim();
	end

	// Watchdog, far beyond the fewer than a hundred cycles the tests need
	initial begin
		#200000;
		failures++;
		end_sim();
	end
endmodule
